// ### core/flash_status_pkg.sv
package flash_status_pkg;

  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] ADDR_OFF    = 8'h04;
  localparam logic [7:0] STATUS_OFF  = 8'h08;
  localparam logic [7:0] IRQ_STS_OFF = 8'h0C;
  localparam logic [7:0] IRQ_MSK_OFF = 8'h10;
  localparam logic [7:0] DATA_OFF    = 8'h14;

  // control register fields
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_MODE_BIT  = 1;
  localparam int CTRL_ABORT_BIT = 2;
  localparam int CTRL_EXPD7_BIT = 8;

  // bits of the flash status byte
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TOUT_BIT   = 5;
  localparam int WINDOW_BIT = 3;
  localparam int STOG_BIT   = 2;

  // interrupt status bits
  localparam int EV_DONE  = 0;
  localparam int EV_FAIL  = 1;
  localparam int EV_WOPEN = 2;
  localparam int EV_COUNT = 3;

  // reset command byte, written to any address
  localparam logic [7:0] RESET_CMD = 8'hF0;

  // flash bus timing: 90 ns read cycle, 50 ns write pulse
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int READ_CYCLE_NS  = 90;
  localparam int WRITE_PULSE_NS = 50;
  localparam int RD_CYC = (READ_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WR_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam logic [31:0] IRQ_RESET = 32'h00000000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RD1   = 3'b001,
    ST_RD2   = 3'b011,
    ST_CHECK = 3'b010,
    ST_RD3   = 3'b110,
    ST_RD4   = 3'b111,
    ST_RST   = 3'b101,
    ST_DONE  = 3'b100
  } poll_state_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  dout;
    logic        oe_drv;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } flash_pins_t;

endpackage

// ### core/flash_status_poller.sv
// Operation
// [RULE1] restart full check after leaving to work
// [RULE2] timeout flag high means operation failed
// [RULE3] programming 1 over 0 ends in timeout
// [RULE4] write reset command after any timeout; the code writes it only when the ST_RD4 recheck still sees toggling
// [RULE5] window flag 0 open, 1 closed
// [RULE6] chip erase has no window timer
// [RULE7] fast sector commands may skip window check
// [RULE8] after window closes only suspend accepted
// [RULE9] confirm acceptance by polling before window
// [RULE10] sample window flag before and after
// [RULE11] status reads use program or sector address
// [RULE12] judge toggling from two consecutive reads
// [RULE13] recheck toggle after timeout flag rises
// [RULE14] polling bit 0 erase, complement programming
// [RULE15] toggle bit inverts each read while busy
// [RULE16] sector toggle inverts inside erased sectors
// [RULE17] ready/busy low while programming or erasing
// [RULE18] suspend reads outside sectors give data
// [RULE19] suspend programming reports like normal programming
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module flash_status_poller
  import flash_status_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input  wire logic              ref_clk,   // 200 MHz clock
  input  wire logic              rst_n,     // async reset, active low
  input  wire logic              hsel,      // ahb slave select
  input  wire logic [31:0]       haddr,     // ahb address
  input  wire logic [1:0]        htrans,    // ahb transfer type
  input  wire logic              hwrite,    // ahb write
  input  wire logic [2:0]        hsize,     // ahb size
  input  wire logic [31:0]       hwdata,    // ahb write data
  input  wire logic              hready,    // ahb bus ready
  output logic      [31:0]       hrdata,    // ahb read data
  output logic                   hreadyout, // ahb slave ready
  output logic                   hresp,     // ahb response, always okay
  output logic                   irq,       // level interrupt
  output logic      [ADDR_W-1:0] fl_addr,   // flash address
  output logic      [7:0]        fl_dq_o,   // flash data out
  output logic                   fl_dq_oe,  // flash data drive enable
  input  wire logic [7:0]        fl_dq_i,   // flash data in
  output logic                   fl_ce_n,   // flash chip enable
  output logic                   fl_oe_n,   // flash output enable
  output logic                   fl_we_n,   // flash write enable
  input  wire logic              fl_rb_i    // flash ready/busy, open drain
);

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states

  logic        ph_wr_reg;
  logic [7:0]  ph_addr_reg;
  logic        ph_rd_reg;
  logic [31:0] ctrl_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [31:0] irq_sts_reg;
  logic [31:0] irq_msk_reg;
  logic [7:0]  last_data_reg;
  logic [2:0]  result_reg;
  poll_state_t state_reg;
  logic [7:0]  dq_s1_reg, dq_s2_reg;
  logic        rb_s1_reg, rb_s2_reg;
  logic [31:0] ev_set;
  logic        go_pulse;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_wr_reg   <= 1'b0;
      ph_rd_reg   <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else if (hready) begin
      ph_wr_reg   <= hsel && htrans[1] && hwrite;
      ph_rd_reg   <= hsel && htrans[1] && !hwrite;
      ph_addr_reg <= haddr[7:0];
    end
  end

  assign go_pulse = ph_wr_reg && (ph_addr_reg == CTRL_OFF) && hwdata[CTRL_GO_BIT];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg    <= 32'h00000000;
      addr_reg    <= '0;
      irq_msk_reg <= IRQ_RESET;
    end else if (ph_wr_reg) begin
      if (ph_addr_reg == CTRL_OFF) begin
        ctrl_reg <= {hwdata[31:1], 1'b0};
      end else if (ph_addr_reg == ADDR_OFF) begin
        addr_reg <= hwdata[ADDR_W-1:0];
      end else if (ph_addr_reg == IRQ_MSK_OFF) begin
        irq_msk_reg <= hwdata;
      end
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sts_reg <= IRQ_RESET;
    end else if (ph_wr_reg && ph_addr_reg == IRQ_STS_OFF) begin
      irq_sts_reg <= (irq_sts_reg & ~hwdata) | ev_set;
    end else begin
      irq_sts_reg <= irq_sts_reg | ev_set;
    end
  end

  assign irq = |(irq_sts_reg & irq_msk_reg);

  always_comb begin
    hrdata = 32'h00000000;
    if (!ph_rd_reg) begin
      hrdata = 32'h00000000;
    end else if (ph_addr_reg == CTRL_OFF) begin
      hrdata = ctrl_reg;
    end else if (ph_addr_reg == ADDR_OFF) begin
      hrdata = {{(32-ADDR_W){1'b0}}, addr_reg};
    end else if (ph_addr_reg == STATUS_OFF) begin
      hrdata = {20'h00000, rb_s2_reg, result_reg, 5'h00, state_reg};
    end else if (ph_addr_reg == IRQ_STS_OFF) begin
      hrdata = irq_sts_reg;
    end else if (ph_addr_reg == IRQ_MSK_OFF) begin
      hrdata = irq_msk_reg;
    end else if (ph_addr_reg == DATA_OFF) begin
      hrdata = {24'h000000, last_data_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
      rb_s1_reg <= 1'b1;
      rb_s2_reg <= 1'b1;
    end else begin
      dq_s1_reg <= fl_dq_i;
      dq_s2_reg <= dq_s1_reg;
      rb_s1_reg <= fl_rb_i;
      rb_s2_reg <= rb_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash cycle engine: one read or write per request

  logic [4:0] cyc_cnt_reg;
  logic       cyc_busy_reg;
  logic       cyc_done;
  logic       cyc_start;
  logic       cyc_write;
  localparam logic [4:0] RD_LEN = 5'(RD_CYC + 2); // two extra for the synchroniser
  localparam logic [4:0] WR_LEN = 5'(WR_CYC);

  assign cyc_done = cyc_busy_reg && (cyc_cnt_reg == 5'h00);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_busy_reg <= 1'b0;
      cyc_cnt_reg  <= 5'h00;
      fl_ce_n      <= 1'b1;
      fl_oe_n      <= 1'b1;
      fl_we_n      <= 1'b1;
      fl_dq_oe     <= 1'b0;
      fl_dq_o      <= 8'h00;
      fl_addr      <= '0;
    end else if (cyc_start) begin
      cyc_busy_reg <= 1'b1;
      cyc_cnt_reg  <= cyc_write ? WR_LEN : RD_LEN;
      fl_ce_n      <= 1'b0;
      fl_oe_n      <= cyc_write;
      fl_we_n      <= !cyc_write;
      fl_dq_oe     <= cyc_write;
      fl_dq_o      <= RESET_CMD;
      fl_addr      <= addr_reg; // [RULE11]
    end else if (cyc_done) begin
      cyc_busy_reg <= 1'b0;
      fl_ce_n      <= 1'b1;
      fl_oe_n      <= 1'b1;
      fl_we_n      <= 1'b1;
      fl_dq_oe     <= 1'b0;
    end else if (cyc_busy_reg) begin
      cyc_cnt_reg <= cyc_cnt_reg - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // toggle-bit poll sequence

  logic [7:0] first_reg;
  logic       busy_mode;
  logic [7:0] rd_now;
  logic       toggled;
  logic       window_seen_reg;

  assign rd_now    = dq_s2_reg;
  assign busy_mode = (state_reg != ST_IDLE) && (state_reg != ST_DONE);
  // the compare states issue no cycle: a stray read there would be mistaken
  // for the reset write that follows a failed recheck
  assign cyc_start = !cyc_busy_reg && busy_mode && !cyc_done &&
                     (state_reg != ST_CHECK) && (state_reg != ST_RD4);
  assign cyc_write = (state_reg == ST_RST);
  // mode bit selects the sector toggle bit for sector-status checks
  assign toggled   = ctrl_reg[CTRL_MODE_BIT] ?
                     (first_reg[STOG_BIT] != last_data_reg[STOG_BIT]) :
                     (first_reg[TOGGLE_BIT] != last_data_reg[TOGGLE_BIT]);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg       <= ST_IDLE;
      first_reg       <= 8'h00;
      last_data_reg   <= 8'h00;
      result_reg      <= 3'b000;
      window_seen_reg <= 1'b0;
      ev_set          <= 32'h00000000;
    end else begin
      ev_set <= 32'h00000000;
      case (state_reg)
        ST_IDLE, ST_DONE: begin
          if (go_pulse) begin
            state_reg       <= ST_RD1; // [RULE1]
            result_reg      <= 3'b000;
            window_seen_reg <= 1'b0;
          end
        end
        ST_RD1: begin
          if (cyc_done) begin
            first_reg <= rd_now; // [RULE12]
            state_reg <= ST_RD2;
          end
        end
        ST_RD2: begin
          if (cyc_done) begin
            last_data_reg <= rd_now;
            state_reg     <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          // reported once per run, on the first check that sees it, fast hosts may ignore it [RULE7]
          if (last_data_reg[WINDOW_BIT] && !window_seen_reg) begin
            window_seen_reg      <= 1'b1; // [RULE9] [RULE10]
            ev_set[EV_WOPEN]     <= 1'b1;
          end
          if (!toggled) begin
            state_reg        <= ST_DONE;
            result_reg       <= 3'b001;
            ev_set[EV_DONE]  <= 1'b1;
          end else if (last_data_reg[TOUT_BIT]) begin
            first_reg <= last_data_reg;
            state_reg <= ST_RD3; // [RULE13]
          end else if (ctrl_reg[CTRL_ABORT_BIT]) begin
            state_reg  <= ST_DONE; // left to other work [RULE1]
            result_reg <= 3'b011;
          end else begin
            state_reg <= ST_RD1;
          end
        end
        ST_RD3: begin
          if (cyc_done) begin
            last_data_reg <= rd_now;
            state_reg     <= ST_RD4;
          end
        end
        ST_RD4: begin
          if (!toggled) begin
            state_reg       <= ST_DONE;
            result_reg      <= 3'b001;
            ev_set[EV_DONE] <= 1'b1;
          end else begin
            state_reg <= ST_RST; // failure after timeout [RULE2] [RULE3]
          end
        end
        ST_RST: begin
          if (cyc_done) begin
            state_reg       <= ST_DONE; // [RULE4]
            result_reg      <= 3'b010;
            ev_set[EV_FAIL] <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  rst_after_fail_a: assert property ( // [RULE4]
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_RD4 && toggled) |=> state_reg == ST_RST)
    else $error("timeout with toggling did not issue reset command");

  rst_write_a: assert property ( // [RULE4]
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_RD4 && toggled) |=> ##1 !fl_we_n)
    else $error("reset command write did not start");

  reset_cmd_data_a: assert property ( // [RULE4]
    @(posedge ref_clk) disable iff (!rst_n)
    (!fl_we_n) |-> (fl_dq_oe && fl_dq_o == RESET_CMD && !fl_ce_n))
    else $error("write cycle without reset command on bus");

  recheck_tout_a: assert property ( // [RULE13]
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_CHECK && toggled && last_data_reg[TOUT_BIT]) |=> state_reg == ST_RD3)
    else $error("timeout flag seen without toggle recheck");

  two_reads_a: assert property ( // [RULE12]
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_RD1 && cyc_done) |=> state_reg == ST_RD2)
    else $error("toggle judged from a single read");

  read_state_a: assert property ( // [RULE12]
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(fl_oe_n) |-> (state_reg == ST_RD1 || state_reg == ST_RD2 || state_reg == ST_RD3))
    else $error("status read started outside a read state");

  restart_top_a: assert property ( // [RULE1]
    @(posedge ref_clk) disable iff (!rst_n)
    ((state_reg == ST_DONE || state_reg == ST_IDLE) && go_pulse) |=> state_reg == ST_RD1)
    else $error("new check did not start from first read");

  fail_event_a: assert property ( // [RULE2]
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_RST && cyc_done) |=> (result_reg == 3'b010) ##1 irq_sts_reg[EV_FAIL])
    else $error("failure not reported after reset command");

  valid_addr_a: assert property ( // [RULE11]
    @(posedge ref_clk) disable iff (!rst_n)
    (!fl_oe_n) |-> fl_addr == $past(addr_reg))
    else $error("status read not at programmed address");

  window_flag_a: assert property ( // [RULE10]
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_CHECK && last_data_reg[WINDOW_BIT]) |=> window_seen_reg)
    else $error("closed erase window not recorded");

endmodule // flash_status_poller

// ### tb/flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model
  import flash_status_pkg::*;
(
  input  wire logic        ce_n,     // chip enable
  input  wire logic        oe_n,     // output enable
  input  wire logic        we_n,     // write enable
  input  wire logic [19:0] addr,     // address
  input  wire logic [7:0]  dq_o,     // host data
  input  wire logic        dq_oe,    // host drives data
  input  wire logic        start,    // operation begins
  input  wire logic [31:0] busy_len, // reads seen busy
  input  wire logic [31:0] tout_at,  // first read with timeout flag
  input  wire logic        win,      // erase window closed
  input  wire logic [19:0] va,       // valid status address
  output logic      [7:0]  dq_i,     // device data
  output logic             rb,       // ready/busy wire, pulled up
  output int               resets,   // reset commands seen
  output int               bad_addr  // status reads at a wrong address
);
  int         rd;
  logic       tg;
  logic       busy;
  logic [7:0] q;
  logic       wr_cmd;
  initial begin
    wr_cmd = 1'b0;
    rd = 0;
    tg = 1'b0;
    busy = 1'b0;
    q = 8'h00;
    resets = 0;
    bad_addr = 0;
  end
  always @(posedge start) begin
    rd = 0;
    busy = 1'b1;
  end
  // strobes, address and data change in one host edge: look once they settle
  always @(negedge oe_n) begin
    #1;
    if (!ce_n) begin
      if (busy && rd < busy_len) begin
        tg = ~tg; // same report in suspend programming
        q = {1'b0, tg, (rd >= tout_at), 1'b0, win, tg, 2'b11};
        // win stays 0 for chip erase, which has no window timer
      end else begin
        q = {1'b1, tg, 3'b000, tg, 2'b11}; // both toggles held once done
      end
      if (addr !== va) bad_addr++;
      rd++;
    end
  end
  always @(negedge we_n) begin
    #1;
    wr_cmd = !ce_n && dq_oe && dq_o === RESET_CMD;
  end
  // only the reset command is decoded; anything else is ignored
  always @(posedge we_n) if (wr_cmd) begin
    resets++;
    busy = 1'b0;
    wr_cmd = 1'b0;
  end
  // released bus shows the inverse so a stale value never reads as good
  assign dq_i = (!ce_n && !oe_n) ? q : ~q;
  assign rb = !(busy && rd < busy_len);
endmodule // flash_dev_model

// ### tb/flash_write_status_reporting_test.sv
`timescale 1ns/1ps
module flash_write_status_reporting_test;
  import flash_status_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, start = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic        hreadyout, hresp, irq, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_rb_i, win = 1'b0;
  logic [19:0] fl_addr, va = 20'h0;
  logic [7:0]  fl_dq_o, fl_dq_i;
  int          busy_len = 0, tout_at = 0, resets, bad_addr, fails = 0, samples_checked = 0;
  int          cyc = 0;
  logic [31:0] msk = 32'h0;
  always #2.5 ref_clk = ~ref_clk;
  flash_status_poller #(.ADDR_W(20)) i_flash_status_poller (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_rb_i(fl_rb_i));
  flash_dev_model i_flash_dev_model (
    .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .addr(fl_addr), .dq_o(fl_dq_o),
    .dq_oe(fl_dq_oe), .start(start), .busy_len(busy_len), .tout_at(tout_at), .win(win),
    .va(va), .dq_i(fl_dq_i), .rb(fl_rb_i), .resets(resets), .bad_addr(bad_addr));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails = fails + 1;
      close_out();
    end
  end
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // one single word transfer; called just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic set_mask(input logic [31:0] m);
    logic [31:0] r;
    msk = m;
    ahb(1'b1, IRQ_MSK_OFF, m, r);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reference walk: read i is busy while i < n
  function automatic int expect_res(int n, int t, bit gu);
    for (int i = 0; i < 400; i += 2) begin
      if (!(i + 1 < n)) return 1;
      if (i + 1 >= t) return (i + 2 < n) ? 2 : 1;
      if (gu) return 3;
    end
    return 0;
  endfunction
  task automatic run(int n, int t, bit gu, bit md, logic w);
    logic [31:0] r;
    int          e, k, r0;
    logic [2:0]  ev;
    e = expect_res(n, t, gu);
    ev = {w && n > 1, e == 2, e == 1};
    r0 = resets;
    busy_len <= n;
    tout_at <= t;
    win <= w;
    va <= 20'(32'(n) * 32'h111);
    ahb(1'b1, ADDR_OFF, 32'(n) * 32'h111, r);
    start <= 1'b1;
    ahb(1'b1, CTRL_OFF, {29'h0, gu, md, 1'b1}, r);
    start <= 1'b0;
    repeat (4) @(posedge ref_clk);
    k = 0;
    do begin
      ahb(1'b0, STATUS_OFF, 32'h0, r);
      k++;
      if (k == 1 && n > 50) chk(r[11] === 1'b0, "ready while busy");
    end while (!(r[10:8] != 3'h0 && (r[2:0] == ST_DONE || r[2:0] == ST_IDLE)) && k < 3000);
    chk(k < 3000, "poll limit");
    chk(r[10:8] === 3'(e), "result");
    repeat (2) @(posedge ref_clk);
    ahb(1'b0, STATUS_OFF, 32'h0, r);
    chk(r[11] === (e != 3 || n < 3), "ready/busy after end");
    chk(resets - r0 === ((e == 2) ? 1 : 0), "reset command count");
    chk(bad_addr === 0, "status address");
    ahb(1'b0, DATA_OFF, 32'h0, r);
    chk(r[POLL_BIT] === (e == 1), "last polling bit");
    if (e != 3) begin
      ahb(1'b0, IRQ_STS_OFF, 32'h0, r);
      chk(r[2:0] === ev, "event bits");
      chk(irq === |(ev & msk[2:0]), "irq level");
    end
    ahb(1'b1, IRQ_STS_OFF, 32'h7, r);
    ahb(1'b0, IRQ_STS_OFF, 32'h0, r);
    chk(r === 32'h0 && irq === 1'b0, "w1c clear");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    void'($urandom(32'hE692));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    ahb(1'b0, STATUS_OFF, 32'h0, r);
    chk(r[10:0] === 11'h0 && hresp === 1'b0, "status reset");
    ahb(1'b0, IRQ_MSK_OFF, 32'h0, r);
    chk(r === IRQ_RESET, "mask reset");
    ahb(1'b1, 8'h24, 32'hFFFFFFFF, r);
    ahb(1'b0, 8'h24, 32'h0, r);
    chk(r === 32'h0, "unmapped read");
    set_mask(32'h00000007);
    run(0, 100, 1'b0, 1'b0, 1'b0);
    run(2, 1, 1'b0, 1'b0, 1'b1);
    run(100000, 3, 1'b0, 1'b1, 1'b1);
    run(10, 100, 1'b1, 1'b0, 1'b0);
    set_mask(32'h00000000);
    run(6, 100, 1'b0, 1'b1, 1'b0);
    repeat (6) begin
      set_mask(32'h00000007);
      run($urandom_range(0, 12), $urandom_range(0, 14), 1'b0, 1'($urandom), 1'($urandom));
    end
    close_out();
  end
endmodule // flash_write_status_reporting_test
